// ---- dpll_status_feedback_regs_tb.sv ----
`timescale 1ns/1ps
`include "dsfr_cfg.svh"
module dpll_status_feedback_regs_tb;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [9:0]  paddr = 10'h000;
    logic [31:0] pwdata = 32'h0;
    logic        hold = 1'b0;
    logic        lock = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        fb_src;
    logic        fb_en;
    logic [3:0]  low_pw;
    logic [7:0]  win0;
    logic [7:0]  win1;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          mismatches = 0;
    int          check_count = 0;

    dsfr_regs i_dut (
        .i_ref_clk                   (clk),
        .i_rstn                      (rstn),
        .i_psel                      (psel),
        .i_penable                   (penable),
        .i_pwrite                    (pwrite),
        .i_paddr                     (paddr),
        .i_pwdata                    (pwdata),
        .i_dpll_holdover             (hold),
        .i_dpll_locked               (lock),
        .o_prdata                    (prdata),
        .o_pready                    (pready),
        .o_pslverr                   (pslverr),
        .o_feedback_source_choice    (fb_src),
        .o_feedback_use_enable       (fb_en),
        .o_diff_out_low_power        (low_pw),
        .o_input0_phase_window_value (win0),
        .o_input1_phase_window_value (win1),
        .o_irq                       (irq)
    );

    always #5 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: %s got %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        check(n, 32'h1, "wait states");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rchk(input logic [9:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp, "read data");
        check({31'h0, err}, 32'h0, "slave error");
    endtask

    task automatic t_reset();
        check({25'h0, irq, fb_en, fb_src, low_pw}, 32'h0, "reset outputs");
        check({16'h0, win0, win1}, 32'h0202, "reset windows");
        rchk(`DSFR_ADDR_STATE_FLAGS, 32'h0);
        rchk(`DSFR_ADDR_FB_CONTROL, 32'h0);
        rchk(`DSFR_ADDR_OUT_POWER, 32'h0);
        rchk(`DSFR_ADDR_IN0_WINDOW, 32'h2);
        rchk(`DSFR_ADDR_IN1_WINDOW, 32'h2);
        rchk(`DSFR_ADDR_IRQ_STATUS, 32'h0);
        rchk(`DSFR_ADDR_IRQ_ENABLE, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_feedback();
        logic [7:0] tbl [4];
        tbl = '{8'h84, 8'h7b, 8'h04, 8'h80};
        foreach (tbl[i]) begin
            apb(1'b1, `DSFR_ADDR_FB_CONTROL, {24'h0, tbl[i]});
            tick(2);
            check({30'h0, fb_en, fb_src}, {30'h0, tbl[i][7], tbl[i][2]}, "feedback");
            rchk(`DSFR_ADDR_FB_CONTROL, {24'h0, tbl[i] & 8'h84});
        end
        $display("test feedback done");
    endtask

    task automatic t_power();
        logic [7:0] wd;
        for (int i = 0; i < 5; i++) begin
            wd = (i < 4) ? (8'h01 << i) : 8'hf0;
            apb(1'b1, `DSFR_ADDR_OUT_POWER, {24'h0, wd});
            tick(2);
            check({28'h0, low_pw}, {28'h0, wd[3:0]}, "low power");
            rchk(`DSFR_ADDR_OUT_POWER, {28'h0, wd[3:0]});
        end
        $display("test power done");
    endtask

    task automatic t_window();
        apb(1'b1, `DSFR_ADDR_IN0_WINDOW, 32'hff);
        apb(1'b1, `DSFR_ADDR_IN1_WINDOW, 32'h01);
        tick(2);
        check({16'h0, win0, win1}, 32'hff01, "windows");
        rchk(`DSFR_ADDR_IN0_WINDOW, 32'hff);
        rchk(`DSFR_ADDR_IN1_WINDOW, 32'h01);
        $display("test window done");
    endtask

    task automatic t_holdover();
        apb(1'b1, `DSFR_ADDR_IRQ_ENABLE, 32'h1);
        hold <= 1'b1;
        tick(8);
        check({31'h0, irq}, 32'h1, "irq raised");
        rchk(`DSFR_ADDR_IRQ_STATUS, 32'h1);
        apb(1'b1, `DSFR_ADDR_IRQ_ENABLE, 32'h0);
        tick(2);
        check({31'h0, irq}, 32'h0, "irq masked");
        apb(1'b1, `DSFR_ADDR_IRQ_ENABLE, 32'h1);
        tick(2);
        check({31'h0, irq}, 32'h1, "irq unmasked");
        apb(1'b1, `DSFR_ADDR_IRQ_CLEAR, 32'h1);
        tick(2);
        check({31'h0, irq}, 32'h0, "irq cleared");
        rchk(`DSFR_ADDR_IRQ_STATUS, 32'h0);
        rchk(`DSFR_ADDR_IRQ_CLEAR, 32'h0);
        rchk(`DSFR_ADDR_STATE_FLAGS, 32'h1);
        hold <= 1'b0;
        tick(8);
        rchk(`DSFR_ADDR_STATE_FLAGS, 32'h1);
        rchk(`DSFR_ADDR_STATE_FLAGS, 32'h0);
        $display("test holdover done");
    endtask

    task automatic t_lock();
        lock <= 1'b1;
        tick(8);
        check({31'h0, irq}, 32'h0, "lock masked irq");
        rchk(`DSFR_ADDR_STATE_FLAGS, 32'h2);
        rchk(`DSFR_ADDR_STATE_FLAGS, 32'h2);
        lock <= 1'b0;
        tick(8);
        rchk(`DSFR_ADDR_STATE_FLAGS, 32'h2);
        rchk(`DSFR_ADDR_STATE_FLAGS, 32'h0);
        rchk(`DSFR_ADDR_IRQ_STATUS, 32'h2);
        $display("test lock done");
    endtask

    task automatic t_unmapped();
        logic [9:0] tbl [3];
        tbl = '{10'h124, 10'h130, 10'h111};
        foreach (tbl[i]) begin
            apb(1'b0, tbl[i], 32'h0);
            check({err, rd[30:0]}, 32'h80000000, "unmapped read");
        end
        apb(1'b1, 10'h124, 32'h55);
        check({31'h0, err}, 32'h1, "unmapped write");
        rchk(`DSFR_ADDR_IN1_WINDOW, 32'h01);
        $display("test unmapped done");
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #200us;
        mismatches++;
        conclude();
    end

    initial begin
        tick(6);
        rstn <= 1'b1;
        tick(1);
        t_reset();
        t_feedback();
        t_power();
        t_window();
        t_holdover();
        t_lock();
        t_unmapped();
        conclude();
    end
endmodule

// ---- dsfr_cfg.svh ----
`ifndef DSFR_CFG_SVH
`define DSFR_CFG_SVH
// Register indices; each register is one word, so its byte address is four times the index.
`define DSFR_IDX_STATE_FLAGS    8'h44
`define DSFR_IDX_FB_CONTROL     8'h45
`define DSFR_IDX_OUT_POWER      8'h46
`define DSFR_IDX_IN0_WINDOW     8'h47
`define DSFR_IDX_IN1_WINDOW     8'h48
`define DSFR_IDX_IRQ_STATUS     8'h50
`define DSFR_IDX_IRQ_ENABLE     8'h54
`define DSFR_IDX_IRQ_CLEAR      8'h58
`define DSFR_ADDR_STATE_FLAGS   {`DSFR_IDX_STATE_FLAGS, 2'b00}
`define DSFR_ADDR_FB_CONTROL    {`DSFR_IDX_FB_CONTROL, 2'b00}
`define DSFR_ADDR_OUT_POWER     {`DSFR_IDX_OUT_POWER, 2'b00}
`define DSFR_ADDR_IN0_WINDOW    {`DSFR_IDX_IN0_WINDOW, 2'b00}
`define DSFR_ADDR_IN1_WINDOW    {`DSFR_IDX_IN1_WINDOW, 2'b00}
`define DSFR_ADDR_IRQ_STATUS    {`DSFR_IDX_IRQ_STATUS, 2'b00}
`define DSFR_ADDR_IRQ_ENABLE    {`DSFR_IDX_IRQ_ENABLE, 2'b00}
`define DSFR_ADDR_IRQ_CLEAR     {`DSFR_IDX_IRQ_CLEAR, 2'b00}
`define DSFR_RST_FLAGS          8'h00
`define DSFR_RST_FB_CONTROL     8'h00
`define DSFR_RST_OUT_POWER      8'h00
`define DSFR_RST_WINDOW         8'h02
`define DSFR_RST_IRQ            2'h0
`define DSFR_BIT_HOLDOVER       0
`define DSFR_BIT_LOCK           1
`define DSFR_BIT_FB_SOURCE      2
`define DSFR_BIT_FB_ENABLE      7
`define DSFR_FLAGS_MASK         8'h03
`define DSFR_FB_MASK            8'h84
`define DSFR_OUT_POWER_MASK     8'h0f
`define DSFR_WINDOW_STEP_US     10
`define DSFR_CLK_MHZ            100
`endif

// ---- dsfr_pkg.sv ----
package dsfr_pkg;
    typedef enum logic [1:0] {
        DSFR_IDLE   = 2'b00,
        DSFR_ACCESS = 2'b01
    } dsfr_state_t;
endpackage

// ---- dsfr_regs.sv ----
`timescale 1ns/1ps
`include "dsfr_cfg.svh"
// Summary of operation
// - Bit 0 high while DPLL in holdover.
// - Bit 1 high while DPLL locked.
// - Status bits ignore every mask setting.
// - Bit 2 picks feedback input one.
// - Bit 7 enables external feedback use.
// - Bits 0-3 put outputs low power.
// - Input 0 window, 10 us units, default 2.
// - Input 1 window, independent, default 2.
module dsfr_regs (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [9:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic        i_dpll_holdover,
    input  wire logic        i_dpll_locked,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic             o_feedback_source_choice,
    output logic             o_feedback_use_enable,
    output logic      [3:0]  o_diff_out_low_power,
    output logic      [7:0]  o_input0_phase_window_value,
    output logic      [7:0]  o_input1_phase_window_value,
    output logic             o_irq
);

    logic [1:0]  cond;
    logic [7:0]  dpll_state_flags;
    logic [7:0]  feedback_control;
    logic [7:0]  output_power_saving;
    logic [7:0]  input0_phase_window;
    logic [7:0]  input1_phase_window;
    logic [1:0]  irq_status;
    logic [1:0]  irq_enable;
    dsfr_pkg::dsfr_state_t state;
    dsfr_pkg::dsfr_state_t next_state;
    logic [7:0]  next_flags;
    logic [7:0]  next_fb;
    logic [7:0]  next_pw;
    logic [7:0]  next_w0;
    logic [7:0]  next_w1;
    logic [1:0]  next_irq_status;
    logic [1:0]  next_irq_enable;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        wr_en;
    logic        rd_en;

    function automatic logic addr_known(input logic [9:0] a);
        addr_known = (a == `DSFR_ADDR_STATE_FLAGS) || (a == `DSFR_ADDR_FB_CONTROL)
                  || (a == `DSFR_ADDR_OUT_POWER)   || (a == `DSFR_ADDR_IN0_WINDOW)
                  || (a == `DSFR_ADDR_IN1_WINDOW)  || (a == `DSFR_ADDR_IRQ_STATUS)
                  || (a == `DSFR_ADDR_IRQ_ENABLE)  || (a == `DSFR_ADDR_IRQ_CLEAR);
    endfunction

    dsfr_sync #(
        .WIDTH(2)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rstn   (i_rstn),
        .i_async  ({i_dpll_locked, i_dpll_holdover}),
        .o_sync   (cond)
    );

    assign wr_en = (state == dsfr_pkg::DSFR_ACCESS) && i_psel && i_penable && i_pwrite;
    assign rd_en = (state == dsfr_pkg::DSFR_ACCESS) && i_psel && i_penable && !i_pwrite;

    always_comb begin
        next_state      = state;
        next_flags      = dpll_state_flags;
        next_fb         = feedback_control;
        next_pw         = output_power_saving;
        next_w0         = input0_phase_window;
        next_w1         = input1_phase_window;
        next_irq_status = irq_status;
        next_irq_enable = irq_enable;
        next_prdata     = o_prdata;
        next_pready     = 1'b0;
        next_pslverr    = 1'b0;
        unique case (state)
            dsfr_pkg::DSFR_IDLE: begin
                if (i_psel && !i_penable) begin
                    next_state  = dsfr_pkg::DSFR_ACCESS;
                    next_pready = 1'b1;
                    next_pslverr = !addr_known(i_paddr);
                    next_prdata = 32'h0;
                    case (i_paddr)
                        `DSFR_ADDR_STATE_FLAGS: next_prdata[7:0] = dpll_state_flags;
                        `DSFR_ADDR_FB_CONTROL:  next_prdata[7:0] = feedback_control;
                        `DSFR_ADDR_OUT_POWER:   next_prdata[7:0] = output_power_saving;
                        `DSFR_ADDR_IN0_WINDOW:  next_prdata[7:0] = input0_phase_window;
                        `DSFR_ADDR_IN1_WINDOW:  next_prdata[7:0] = input1_phase_window;
                        `DSFR_ADDR_IRQ_STATUS:  next_prdata[1:0] = irq_status;
                        `DSFR_ADDR_IRQ_ENABLE:  next_prdata[1:0] = irq_enable;
                        default:                next_prdata = 32'h0;
                    endcase
                end
            end
            dsfr_pkg::DSFR_ACCESS: begin
                next_state = dsfr_pkg::DSFR_IDLE;
                if (wr_en) begin
                    case (i_paddr)
                        `DSFR_ADDR_FB_CONTROL: next_fb = i_pwdata[7:0] & `DSFR_FB_MASK;
                        `DSFR_ADDR_OUT_POWER:  next_pw = i_pwdata[7:0] & `DSFR_OUT_POWER_MASK;
                        `DSFR_ADDR_IN0_WINDOW: next_w0 = i_pwdata[7:0];
                        `DSFR_ADDR_IN1_WINDOW: next_w1 = i_pwdata[7:0];
                        `DSFR_ADDR_IRQ_ENABLE: next_irq_enable = i_pwdata[1:0];
                        `DSFR_ADDR_IRQ_CLEAR:  next_irq_status = irq_status & ~i_pwdata[1:0];
                        default: ;
                    endcase
                end
                if (rd_en && (i_paddr == `DSFR_ADDR_STATE_FLAGS)) begin
                    next_flags = dpll_state_flags & ~o_prdata[7:0];
                end
            end
            default: next_state = dsfr_pkg::DSFR_IDLE;
        endcase
        next_flags[`DSFR_BIT_HOLDOVER] = next_flags[`DSFR_BIT_HOLDOVER] | cond[0];
        next_flags[`DSFR_BIT_LOCK]     = next_flags[`DSFR_BIT_LOCK] | cond[1];
        next_irq_status = next_irq_status | (cond & ~dpll_state_flags[1:0]);
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state                       <= dsfr_pkg::DSFR_IDLE;
            dpll_state_flags            <= `DSFR_RST_FLAGS;
            feedback_control            <= `DSFR_RST_FB_CONTROL;
            output_power_saving         <= `DSFR_RST_OUT_POWER;
            input0_phase_window         <= `DSFR_RST_WINDOW;
            input1_phase_window         <= `DSFR_RST_WINDOW;
            irq_status                  <= `DSFR_RST_IRQ;
            irq_enable                  <= `DSFR_RST_IRQ;
            o_prdata                    <= 32'h0;
            o_pready                    <= 1'b0;
            o_pslverr                   <= 1'b0;
            o_feedback_source_choice    <= 1'b0;
            o_feedback_use_enable       <= 1'b0;
            o_diff_out_low_power        <= 4'h0;
            o_input0_phase_window_value <= `DSFR_RST_WINDOW;
            o_input1_phase_window_value <= `DSFR_RST_WINDOW;
            o_irq                       <= 1'b0;
        end else begin
            state                       <= next_state;
            dpll_state_flags            <= next_flags;
            feedback_control            <= next_fb;
            output_power_saving         <= next_pw;
            input0_phase_window         <= next_w0;
            input1_phase_window         <= next_w1;
            irq_status                  <= next_irq_status;
            irq_enable                  <= next_irq_enable;
            o_prdata                    <= next_prdata;
            o_pready                    <= next_pready;
            o_pslverr                   <= next_pslverr;
            o_feedback_source_choice    <= next_fb[`DSFR_BIT_FB_SOURCE];
            o_feedback_use_enable       <= next_fb[`DSFR_BIT_FB_ENABLE];
            o_diff_out_low_power        <= next_pw[3:0];
            o_input0_phase_window_value <= next_w0;
            o_input1_phase_window_value <= next_w1;
            o_irq                       <= |(next_irq_status & next_irq_enable);
        end
    end

    property p_holdover_sets;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        cond[0] |=> dpll_state_flags[`DSFR_BIT_HOLDOVER];
    endproperty
    a_holdover_sets: assert property (p_holdover_sets) else $error("holdover not set");

    property p_lock_sets;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        cond[1] |=> dpll_state_flags[`DSFR_BIT_LOCK];
    endproperty
    a_lock_sets: assert property (p_lock_sets) else $error("lock not set");

    property p_unmaskable;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (cond != 2'b00) |=> ((dpll_state_flags[1:0] & $past(cond)) == $past(cond));
    endproperty
    a_unmaskable: assert property (p_unmaskable) else $error("status masked");

    property p_sticky_hold;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (dpll_state_flags[0] && !(rd_en && i_paddr == `DSFR_ADDR_STATE_FLAGS))
            |=> dpll_state_flags[0];
    endproperty
    a_sticky_hold: assert property (p_sticky_hold) else $error("sticky lost");

    property p_fb_source;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (wr_en && i_paddr == `DSFR_ADDR_FB_CONTROL)
            |=> (o_feedback_source_choice == $past(i_pwdata[2]));
    endproperty
    a_fb_source: assert property (p_fb_source) else $error("source wrong");

    property p_fb_enable;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (wr_en && i_paddr == `DSFR_ADDR_FB_CONTROL)
            |=> (o_feedback_use_enable == $past(i_pwdata[`DSFR_BIT_FB_ENABLE]));
    endproperty
    a_fb_enable: assert property (p_fb_enable) else $error("enable wrong");

    property p_low_power;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (wr_en && i_paddr == `DSFR_ADDR_OUT_POWER)
            |=> (o_diff_out_low_power == $past(i_pwdata[3:0]));
    endproperty
    a_low_power: assert property (p_low_power) else $error("power bits wrong");

    property p_win0;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        !(wr_en && i_paddr == `DSFR_ADDR_IN0_WINDOW) |=> $stable(o_input0_phase_window_value);
    endproperty
    a_win0: assert property (p_win0) else $error("window0 changed");

    property p_win1;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (wr_en && i_paddr == `DSFR_ADDR_IN0_WINDOW) |=> $stable(o_input1_phase_window_value);
    endproperty
    a_win1: assert property (p_win1) else $error("window1 not independent");

    property p_fb_hold;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        !(wr_en && i_paddr == `DSFR_ADDR_FB_CONTROL)
            |=> $stable({o_feedback_use_enable, o_feedback_source_choice});
    endproperty
    a_fb_hold: assert property (p_fb_hold) else $error("feedback changed");

    property p_fb_reserved;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (feedback_control & ~`DSFR_FB_MASK) == 8'h00;
    endproperty
    a_fb_reserved: assert property (p_fb_reserved) else $error("feedback reserved set");

    property p_power_hold;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        !(wr_en && i_paddr == `DSFR_ADDR_OUT_POWER) |=> $stable(o_diff_out_low_power);
    endproperty
    a_power_hold: assert property (p_power_hold) else $error("power bits changed");

    property p_pw_reserved;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (output_power_saving & ~`DSFR_OUT_POWER_MASK) == 8'h00;
    endproperty
    a_pw_reserved: assert property (p_pw_reserved) else $error("power reserved set");

    property p_flags_reserved;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (dpll_state_flags & ~`DSFR_FLAGS_MASK) == 8'h00;
    endproperty
    a_flags_reserved: assert property (p_flags_reserved) else $error("status reserved set");

    property p_win0_write;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (wr_en && i_paddr == `DSFR_ADDR_IN0_WINDOW)
            |=> (o_input0_phase_window_value == $past(i_pwdata[7:0]));
    endproperty
    a_win0_write: assert property (p_win0_write) else $error("window0 not written");

    property p_win1_write;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (wr_en && i_paddr == `DSFR_ADDR_IN1_WINDOW)
            |=> (o_input1_phase_window_value == $past(i_pwdata[7:0]));
    endproperty
    a_win1_write: assert property (p_win1_write) else $error("window1 not written");

    property p_lock_hold;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (dpll_state_flags[`DSFR_BIT_LOCK] && !(rd_en && i_paddr == `DSFR_ADDR_STATE_FLAGS))
            |=> dpll_state_flags[`DSFR_BIT_LOCK];
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("lock sticky lost");

    property p_read_clear;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (rd_en && i_paddr == `DSFR_ADDR_STATE_FLAGS && cond == 2'b00)
            |=> ((dpll_state_flags[1:0] & $past(o_prdata[1:0])) == 2'b00);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear");

    property p_hold_event;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (cond[0] && !dpll_state_flags[`DSFR_BIT_HOLDOVER]) |=> irq_status[0];
    endproperty
    a_hold_event: assert property (p_hold_event) else $error("holdover event lost");
endmodule

// ---- dsfr_sync.sv ----
`timescale 1ns/1ps
// Three-stage synchroniser; a change is accepted when stages two and three agree.
module dsfr_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_rstn,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_sync;

    always_comb begin
        next_sync = o_sync;
        for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
                next_sync[i] = stage3[i];
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta   <= '0;
            stage2 <= '0;
            stage3 <= '0;
            o_sync <= '0;
        end else begin
            meta   <= i_async;
            stage2 <= meta;
            stage3 <= stage2;
            o_sync <= next_sync;
        end
    end
endmodule
